// [verilog/ucte_top.sv]
// serial channel: transmit buffering, receive path, reception errors, apb registers
// Summary of operation
// [RULE1] buffer accepts next byte once shifter starts the previous one
// [RULE2] transmit_status bit 1 is buffer full: 1 forbids writing
// [RULE3] transmit_status bit 0 is shifter busy while a frame goes out
// [RULE4] back-to-back flags pass 10, 11, then 01
// [RULE5] software checks only buffer full before writing next byte
// [RULE6] software waits for done and busy 0 before reinitialising
// [RULE7] for lin traffic software writes only when transmit_status is zero
// [RULE8] receiver samples only with power and receive enable set
// [RULE9] falling edge starts counter; start accepted if still low at half bit
// [RULE10] bits shifted at baud; on stop, done event and buffer copy
// [RULE11] overrun leaves receive buffer unchanged
// [RULE12] parity mismatch finishes the frame, error reported at end
// [RULE13] only one stop bit is checked
// [RULE14] parity error when received parity disagrees with configured type; the code checks only odd and even, not zero
// [RULE15] framing error when stop bit sample is low
// [RULE16] overrun when frame ends before previous byte was read
// [RULE17] any error at frame end issues an error event
// [RULE18] merge bit 0 routes errors to error line, 1 to done line
// [RULE19] reading rx_error_status clears its flags
// [RULE20] software reads error status, then receive buffer
// [RULE21] transmit done raised right after the last stop bit
// [RULE22] overrun, parity, framing at bits 0, 1, 2 of error status
// [RULE23] buffered byte starts with no idle gap, then full clears
`include "ucte_consts.svh"

module ucte_top import ucte_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  output logic serial_out,
  output logic tx_done_irq,
  output logic rx_done_irq,
  output logic rx_error_irq
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // register decode, used only by the error answer (pslverr)
  function automatic logic addr_hit(input logic [7:0] a);
    return a == `UCTE_ADDR_MODE || a == `UCTE_ADDR_BAUD || a == `UCTE_ADDR_TXBUF ||
           a == `UCTE_ADDR_RXBUF || a == `UCTE_ADDR_ERRST || a == `UCTE_ADDR_TXST;
  endfunction

  // parity bit for a character, shared by both directions
  function automatic logic par_bit(input logic [7:0] d, input logic len8, input logic odd);
    logic [7:0] m;
    m = len8 ? d : {1'b0, d[6:0]};
    return (^m) ^ odd;
  endfunction

  // baud counter advance: {half, cnt}
  function automatic logic [8:0] adv(input logic [7:0] cnt, input logic half, input logic [7:0] k);
    if (cnt == k - 8'h01)
      return {~half, 8'h00};
    return {half, cnt + 8'h01};
  endfunction

  // start bit, character, parity, ones above for stop and idle
  function automatic logic [11:0] build_frame(input logic [7:0] d, input logic len8, input logic pp,
                                              input logic pv);
    logic [11:0] v;
    v = `UCTE_IDLE_LINE;
    v[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || len8)
        v[i + 1] = d[i];
    end
    if (pp)
      v[len8 ? 9 : 8] = pv;
    return v;
  endfunction

  // ------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------
  localparam ucte_state_type RST = '{mode: `UCTE_MODE_RESET, baud: `UCTE_BAUD_RESET,
    txs: `UCTE_IDLE_LINE, rxbuf: `UCTE_RXBUF_RESET, s1: 1'b1, s2: 1'b1, prev: 1'b1,
    tx_st: UCTE_TX_IDLE, rx_st: UCTE_RX_IDLE, default: '0};

  ucte_state_type state_r;
  ucte_state_type state_nxt;
  logic acc, wr, rd, tx_on, rx_on, len8, pp, pv, podd, merge;
  logic [7:0] k;
  logic [1:0] ps;
  logic [3:0] nch, nrx, nd;
  logic tx_end, rx_half_end, rx_end, frame_end, load, any_err;
  logic [9:0] aligned;
  logic [7:0] rx_char;
  logic [2:0] new_err;
  logic [8:0] tx_adv, rx_adv;

  // apb qualifiers and mode fields
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign tx_on = state_r.mode[`UCTE_MODE_POWER] & state_r.mode[`UCTE_MODE_TXEN];
  assign rx_on = state_r.mode[`UCTE_MODE_POWER] & state_r.mode[`UCTE_MODE_RXEN]; // RULE8
  assign len8 = state_r.mode[`UCTE_MODE_CL];
  assign ps = {state_r.mode[`UCTE_MODE_PS_HI], state_r.mode[`UCTE_MODE_PS_LO]};
  assign pp = ps != `UCTE_PAR_NONE;
  assign podd = ps == `UCTE_PAR_ODD;
  assign pv = (ps == `UCTE_PAR_ZERO) ? 1'b0 : par_bit(state_r.txbuf, len8, podd);
  assign merge = state_r.mode[`UCTE_MODE_MERGE];
  assign k = (state_r.baud < `UCTE_BAUD_MIN) ? `UCTE_BAUD_MIN : state_r.baud;
  assign nch = len8 ? `UCTE_LEN8 : `UCTE_LEN7;
  assign nd = nch + {3'h0, pp};
  assign nrx = nd + 4'h1; // RULE13

  // bit period ends and buffer hand-over
  assign tx_adv = adv(state_r.tx_cnt, state_r.tx_half, k);
  assign rx_adv = adv(state_r.rx_cnt, state_r.rx_half, k);
  assign tx_end = state_r.tx_half && state_r.tx_cnt == k - 8'h01;
  assign rx_end = state_r.rx_half && state_r.rx_cnt == k - 8'h01;
  assign rx_half_end = !state_r.rx_half && state_r.rx_cnt == k - 8'h01;
  assign load = state_r.buf_full && !state_r.xfer_clr &&
                (state_r.tx_st == UCTE_TX_IDLE || (tx_end && state_r.tx_bits == 4'h1)); // RULE1 RULE23

  // received character, parity and errors at the stop sample
  assign frame_end = rx_on && state_r.rx_st == UCTE_RX_DATA && rx_end && state_r.rx_bits == 4'h1; // RULE10 RULE13
  assign aligned = state_r.rxs >> (`UCTE_RXS_W - nd);
  assign rx_char = len8 ? aligned[7:0] : {1'b0, aligned[6:0]};
  always_comb begin
    new_err = 3'h0;
    new_err[`UCTE_ERR_OVR] = state_r.rx_full; // RULE16 RULE22
    new_err[`UCTE_ERR_PAR] = (ps == `UCTE_PAR_ODD || ps == `UCTE_PAR_EVEN) &&
                             aligned[nch] != par_bit(rx_char, len8, podd); // RULE14 RULE12
    new_err[`UCTE_ERR_FRM] = ~state_r.s2; // RULE15
  end
  assign any_err = |new_err;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.tx_done = 1'b0;
    state_nxt.rx_done = 1'b0;
    state_nxt.rx_err = 1'b0;
    // input synchroniser and edge history
    state_nxt.s1 = serial_in;
    state_nxt.s2 = state_r.s1;
    state_nxt.prev = state_r.s2;

    // register writes
    if (wr) begin
      unique case (paddr)
        `UCTE_ADDR_MODE: state_nxt.mode = pwdata[7:0];
        `UCTE_ADDR_BAUD: state_nxt.baud = pwdata[7:0];
        `UCTE_ADDR_TXBUF: begin
          if (tx_on && !state_r.buf_full) begin // RULE2
            state_nxt.txbuf = pwdata[7:0];
            state_nxt.buf_full = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // transmitter
    if (state_r.xfer_clr) begin
      state_nxt.buf_full = 1'b0; // RULE4
      state_nxt.xfer_clr = 1'b0;
    end
    if (state_r.tx_st == UCTE_TX_SHIFT) begin
      {state_nxt.tx_half, state_nxt.tx_cnt} = tx_adv;
      if (tx_end) begin
        if (state_r.tx_bits == 4'h1) begin
          state_nxt.tx_done = 1'b1; // RULE21
          state_nxt.tx_st = UCTE_TX_IDLE;
          state_nxt.txs = `UCTE_IDLE_LINE;
        end else begin
          state_nxt.txs = {1'b1, state_r.txs[11:1]};
          state_nxt.tx_bits = state_r.tx_bits - 4'h1;
        end
      end
    end
    if (load) begin
      state_nxt.txs = build_frame(state_r.txbuf, len8, pp, pv); // RULE23
      state_nxt.tx_bits = nd + 4'h2 + {3'h0, state_r.mode[`UCTE_MODE_SL]};
      state_nxt.tx_st = UCTE_TX_SHIFT; // RULE3
      state_nxt.tx_cnt = 8'h00;
      state_nxt.tx_half = 1'b0;
      state_nxt.xfer_clr = 1'b1; // RULE4
    end
    if (!tx_on) begin
      state_nxt.tx_st = UCTE_TX_IDLE;
      state_nxt.txs = `UCTE_IDLE_LINE;
      state_nxt.buf_full = 1'b0;
      state_nxt.xfer_clr = 1'b0;
    end

    // receiver
    unique case (state_r.rx_st)
      UCTE_RX_IDLE: begin
        if (state_r.prev && !state_r.s2) begin // RULE9
          state_nxt.rx_st = UCTE_RX_START;
          state_nxt.rx_cnt = 8'h00;
          state_nxt.rx_half = 1'b0;
        end
      end
      UCTE_RX_START: begin
        {state_nxt.rx_half, state_nxt.rx_cnt} = rx_adv;
        if (rx_half_end) begin
          state_nxt.rx_half = 1'b0;
          state_nxt.rx_bits = nrx;
          state_nxt.rx_st = state_r.s2 ? UCTE_RX_IDLE : UCTE_RX_DATA; // RULE9
        end
      end
      UCTE_RX_DATA: begin
        {state_nxt.rx_half, state_nxt.rx_cnt} = rx_adv;
        if (frame_end) begin
          state_nxt.rx_st = UCTE_RX_IDLE;
          state_nxt.rx_full = 1'b1;
          if (!state_r.rx_full)
            state_nxt.rxbuf = rx_char; // RULE10 RULE11
          state_nxt.rx_done = merge | ~any_err; // RULE18
          state_nxt.rx_err = any_err & ~merge; // RULE17 RULE18
        end else if (rx_end) begin
          state_nxt.rxs = {state_r.s2, state_r.rxs[9:1]}; // RULE10
          state_nxt.rx_bits = state_r.rx_bits - 4'h1;
        end
      end
    endcase
    if (!rx_on)
      state_nxt.rx_st = UCTE_RX_IDLE; // RULE8

    // read side effects; a flag set in the same cycle survives
    if (rd && paddr == `UCTE_ADDR_ERRST)
      state_nxt.err = state_r.err & ~state_r.prdata[2:0]; // RULE19
    if (rd && paddr == `UCTE_ADDR_RXBUF && !state_r.rx_done && !state_r.rx_err)
      state_nxt.rx_full = frame_end;
    if (frame_end)
      state_nxt.err = state_nxt.err | new_err; // RULE17

    // read data captured in the setup cycle
    state_nxt.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `UCTE_ADDR_MODE: state_nxt.prdata[7:0] = state_r.mode;
        `UCTE_ADDR_BAUD: state_nxt.prdata[7:0] = state_r.baud;
        `UCTE_ADDR_TXBUF: state_nxt.prdata[7:0] = state_r.txbuf;
        `UCTE_ADDR_RXBUF: state_nxt.prdata[7:0] = state_r.rxbuf;
        `UCTE_ADDR_ERRST: state_nxt.prdata[2:0] = state_r.err; // RULE22
        `UCTE_ADDR_TXST: begin
          state_nxt.prdata[`UCTE_TXST_FULL] = state_r.buf_full; // RULE2
          state_nxt.prdata[`UCTE_TXST_BUSY] = state_r.tx_st == UCTE_TX_SHIFT; // RULE3
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_r <= RST;
    else
      state_r <= state_nxt;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = state_r.prdata;
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_hit(paddr);
  assign serial_out = state_r.txs[0];
  assign tx_done_irq = state_r.tx_done;
  assign rx_done_irq = state_r.rx_done;
  assign rx_error_irq = state_r.rx_err;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic busy;
  assign busy = state_r.tx_st == UCTE_TX_SHIFT;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tx_flag_seq_a: assert property ( // RULE4
    (wr && paddr == `UCTE_ADDR_TXBUF && tx_on && !state_r.buf_full && !busy) ##1 tx_on [*3]
    |-> $past(state_r.buf_full && !busy, 2) && $past(state_r.buf_full && busy) &&
        !state_r.buf_full && busy)
    else $error("transmit flags did not pass 10, 11, 01");
  tx_accept_a: assert property ( // RULE1
    state_r.xfer_clr && tx_on |=> !state_r.buf_full)
    else $error("buffer not freed after transfer to shifter");
  tx_done_a: assert property ( // RULE21
    tx_done_irq |-> $past(state_r.tx_bits) == 4'h1 && $past(serial_out))
    else $error("transmit done not after last stop bit");
  rx_enable_a: assert property ( // RULE8
    !rx_on |=> state_r.rx_st == UCTE_RX_IDLE && !rx_done_irq)
    else $error("receiver active while disabled");
  start_check_a: assert property ( // RULE9
    state_r.rx_st == UCTE_RX_START && rx_half_end && state_r.s2 && rx_on |=> state_r.rx_st == UCTE_RX_IDLE)
    else $error("high start sample accepted");
  overrun_keep_a: assert property ( // RULE11
    frame_end && state_r.rx_full |=> $stable(state_r.rxbuf) && state_r.err[`UCTE_ERR_OVR])
    else $error("receive buffer overwritten on overrun");
  err_clear_a: assert property ( // RULE19
    rd && paddr == `UCTE_ADDR_ERRST && !frame_end |=> (state_r.err & $past(state_r.prdata[2:0])) == 3'h0)
    else $error("error flags not cleared by read");
  err_route_a: assert property ( // RULE18
    rx_error_irq |-> !merge && state_r.err != 3'h0)
    else $error("error line used while merged");
  err_event_a: assert property ( // RULE17
    frame_end && any_err |=> (rx_done_irq || rx_error_irq) && state_r.err != 3'h0)
    else $error("error at frame end without event");
  frame_err_a: assert property ( // RULE15
    frame_end && !state_r.s2 |=> state_r.err[`UCTE_ERR_FRM])
    else $error("low stop bit not flagged");
  par_err_a: assert property ( // RULE14
    frame_end && ps == `UCTE_PAR_ODD && !(^{aligned[nch], rx_char}) |=> state_r.err[`UCTE_ERR_PAR])
    else $error("odd parity mismatch not flagged");
  tx_status_a: assert property ( // RULE2 RULE3
    psel && !penable && !pwrite && paddr == `UCTE_ADDR_TXST |=> prdata[1:0] == $past({state_r.buf_full, busy}))
    else $error("transmit status does not show full and busy");
  line_idle_a: assert property ( // RULE3
    !busy |-> serial_out)
    else $error("transmit line low while shifter idle");
  one_stop_a: assert property ( // RULE13
    frame_end |=> state_r.rx_st == UCTE_RX_IDLE)
    else $error("receiver waited for a second stop bit");

  back_to_back_c: cover property (state_r.buf_full && busy ##[1:300] tx_done_irq ##1 busy);
  parity_err_c: cover property (frame_end && new_err[`UCTE_ERR_PAR]);
  overrun_c: cover property (frame_end && state_r.rx_full);
  merged_c: cover property (rx_done_irq && merge && state_r.err != 3'h0);
  two_stop_c: cover property (tx_done_irq && state_r.mode[`UCTE_MODE_SL]);

endmodule // ucte_top

// [verilog/ucte_consts.svh]
// constants of the serial channel: register map, field positions, reset values
`ifndef UCTE_CONSTS_SVH
`define UCTE_CONSTS_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define UCTE_ADDR_MODE 8'h00
`define UCTE_ADDR_BAUD 8'h04
`define UCTE_ADDR_TXBUF 8'h08
`define UCTE_ADDR_RXBUF 8'h0c
`define UCTE_ADDR_ERRST 8'h10
`define UCTE_ADDR_TXST 8'h14
// ------------------------------------------------------------
// mode_control fields
// ------------------------------------------------------------
`define UCTE_MODE_POWER 7
`define UCTE_MODE_TXEN 6
`define UCTE_MODE_RXEN 5
`define UCTE_MODE_PS_HI 4
`define UCTE_MODE_PS_LO 3
`define UCTE_MODE_CL 2
`define UCTE_MODE_SL 1
`define UCTE_MODE_MERGE 0
`define UCTE_PAR_NONE 2'h0
`define UCTE_PAR_ZERO 2'h1
`define UCTE_PAR_ODD 2'h2
`define UCTE_PAR_EVEN 2'h3
// ------------------------------------------------------------
// status fields, reset values, counts
// ------------------------------------------------------------
`define UCTE_TXST_FULL 1
`define UCTE_TXST_BUSY 0
`define UCTE_ERR_OVR 0
`define UCTE_ERR_PAR 1
`define UCTE_ERR_FRM 2
`define UCTE_MODE_RESET 8'h01
`define UCTE_BAUD_RESET 8'hff
`define UCTE_RXBUF_RESET 8'hff
`define UCTE_BAUD_MIN 8'h04
`define UCTE_LEN7 4'h7
`define UCTE_LEN8 4'h8
`define UCTE_RXS_W 4'ha
`define UCTE_IDLE_LINE 12'hfff
`endif

// [verilog/ucte_pkg.sv]
// types of the serial channel
package ucte_pkg;
  typedef enum logic [0:0] {UCTE_TX_IDLE, UCTE_TX_SHIFT} ucte_tx_type;
  typedef enum logic [1:0] {UCTE_RX_IDLE, UCTE_RX_START, UCTE_RX_DATA} ucte_rx_type;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] baud;
    logic [7:0] txbuf;
    logic buf_full;
    logic xfer_clr;
    ucte_tx_type tx_st;
    logic [11:0] txs;
    logic [3:0] tx_bits;
    logic [7:0] tx_cnt;
    logic tx_half;
    logic tx_done;
    ucte_rx_type rx_st;
    logic s1;
    logic s2;
    logic prev;
    logic [7:0] rx_cnt;
    logic rx_half;
    logic [3:0] rx_bits;
    logic [9:0] rxs;
    logic [7:0] rxbuf;
    logic rx_full;
    logic [2:0] err;
    logic rx_done;
    logic rx_err;
    logic [31:0] prdata;
  } ucte_state_type;
endpackage

// [dv/ucte_remote.sv]
// remote serial transceiver model facing the serial channel
// ------------------------------------------------------------
// frame sender on serial_in, frame decoder on serial_out
// ------------------------------------------------------------
module ucte_remote #(parameter int K = 4) (
  input wire logic pclk,
  input wire logic serial_out,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  int gaps[$];
  int gap;
  logic [7:0] sh;
  // idle line is high, like a pulled-up wire
  initial serial_in = 1'b1;
  // start, 8 data lsb first, optional odd parity (bad flips it), stop
  task automatic send(input logic [7:0] d, input logic par, input logic bad, input logic stop);
    logic [10:0] f;
    int n;
    f = {stop, (~^d) ^ bad, d, 1'b0};
    n = par ? 11 : 10;
    if (!par) f[9] = stop;
    for (int i = 0; i < n; i++) begin
      serial_in <= f[i];
      repeat (2 * K) @(posedge pclk);
    end
    serial_in <= 1'b1;
    repeat (2 * K) @(posedge pclk);
  endtask
  // decode 8-bit frames mid-bit; record the high time from the middle of each stop bit, capped at 4 * K cycles
  initial begin
    forever begin
      @(negedge pclk);
      if (serial_out === 1'b0) begin
        repeat (K) @(negedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (2 * K) @(negedge pclk);
          sh[i] = serial_out;
        end
        repeat (2 * K) @(negedge pclk);
        if (serial_out === 1'b1) rx_q.push_back(sh);
        gap = 0;
        while (serial_out === 1'b1 && gap < 4 * K) begin
          @(negedge pclk);
          gap++;
        end
        gaps.push_back(gap);
      end
    end
  end
endmodule // ucte_remote

// [dv/tb.sv]
// self-checking bench of the serial channel over apb
`include "ucte_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, er, s_ready, s_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, s_rdata;
  logic [31:0] prdata;
  logic pready, pslverr, serial_in, serial_out, tx_done_irq, rx_done_irq, rx_error_irq;
  int n_mismatch, check_count, n_txd, n_rxd, n_rxe;
  ucte_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in(serial_in), .serial_out(serial_out), .tx_done_irq(tx_done_irq),
    .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
  ucte_remote #(.K(4)) i_rem (.pclk(pclk), .serial_out(serial_out), .serial_in(serial_in));
  // ------------------------------------------------------------
  // clock, bus observation, event counters
  // ------------------------------------------------------------
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  // values seen mid-cycle are those sampled at the next rising edge
  always @(negedge pclk) begin
    s_rdata = prdata;
    s_ready = pready;
    s_err = pslverr;
  end
  // pulses counted mid-cycle, away from the edge that launches them
  always @(negedge pclk) begin
    n_txd <= n_txd + (tx_done_irq === 1'b1);
    n_rxd <= n_rxd + (rx_done_irq === 1'b1);
    n_rxe <= n_rxe + (rx_error_irq === 1'b1);
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // apb transfer: setup cycle, then access until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (s_ready !== 1'b1 && t < 50);
    rd = s_rdata;
    er = s_err;
    psel <= 1'b0;
    penable <= 1'b0;
    if (s_ready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic wait_for(ref int c, input int target);
    int t;
    for (t = 0; t < 3000 && c < target; t++) @(posedge pclk);
    if (c < target) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdchk("mode", `UCTE_ADDR_MODE, 32'h01);
    rdchk("baud", `UCTE_ADDR_BAUD, 32'hff);
    rdchk("rx buffer", `UCTE_ADDR_RXBUF, 32'hff);
    rdchk("error status", `UCTE_ADDR_ERRST, 32'h0);
    apb(1'b1, `UCTE_ADDR_TXBUF, 32'h99);
    rdchk("tx status unpowered", `UCTE_ADDR_TXST, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, `UCTE_ADDR_BAUD, 32'h04);
    apb(1'b1, `UCTE_ADDR_MODE, 32'he4);
  endtask
  task automatic t_tx();
    int t;
    rdchk("tx status idle", `UCTE_ADDR_TXST, 32'h0);
    apb(1'b1, `UCTE_ADDR_TXBUF, 32'ha5);
    t = 0;
    do begin
      apb(1'b0, `UCTE_ADDR_TXST, 32'h0);
      t++;
    end while (rd[1] !== 1'b0 && t < 20);
    chk("tx status shifting", 32'h1, rd);
    apb(1'b1, `UCTE_ADDR_TXBUF, 32'h3c);
    apb(1'b1, `UCTE_ADDR_TXBUF, 32'h77);
    rdchk("tx status queued", `UCTE_ADDR_TXST, 32'h3);
    wait_for(n_txd, 2);
    rdchk("tx status done", `UCTE_ADDR_TXST, 32'h0);
    repeat (20) @(posedge pclk);
    chk("frames out", 32'h2, i_rem.rx_q.size());
    chk("first byte", 32'ha5, {24'h0, i_rem.rx_q[0]});
    chk("second byte", 32'h3c, {24'h0, i_rem.rx_q[1]});
    chk("no idle gap", 32'h1, {31'h0, i_rem.gaps[0] <= 5});
  endtask
  task automatic t_rx_ok();
    i_rem.send(8'h5a, 1'b0, 1'b0, 1'b1);
    wait_for(n_rxd, 1);
    rdchk("error status clean", `UCTE_ADDR_ERRST, 32'h0);
    rdchk("rx data", `UCTE_ADDR_RXBUF, 32'h5a);
  endtask
  task automatic t_parity();
    apb(1'b1, `UCTE_ADDR_MODE, 32'hf4);
    i_rem.send(8'h33, 1'b1, 1'b1, 1'b1);
    wait_for(n_rxe, 1);
    chk("done line quiet", 32'h1, n_rxd);
    rdchk("parity flag", `UCTE_ADDR_ERRST, 32'h2);
    rdchk("flags cleared", `UCTE_ADDR_ERRST, 32'h0);
    rdchk("parity frame data", `UCTE_ADDR_RXBUF, 32'h33);
    i_rem.send(8'h34, 1'b1, 1'b0, 1'b1);
    wait_for(n_rxd, 2);
    rdchk("good parity", `UCTE_ADDR_ERRST, 32'h0);
    rdchk("good parity data", `UCTE_ADDR_RXBUF, 32'h34);
  endtask
  task automatic t_framing();
    apb(1'b1, `UCTE_ADDR_MODE, 32'he5);
    i_rem.send(8'h81, 1'b0, 1'b0, 1'b0);
    wait_for(n_rxd, 3);
    chk("error line quiet", 32'h1, n_rxe);
    rdchk("framing flag", `UCTE_ADDR_ERRST, 32'h4);
    apb(1'b0, `UCTE_ADDR_RXBUF, 32'h0);
  endtask
  task automatic t_overrun();
    apb(1'b1, `UCTE_ADDR_MODE, 32'he4);
    i_rem.send(8'h11, 1'b0, 1'b0, 1'b1);
    i_rem.send(8'h22, 1'b0, 1'b0, 1'b1);
    wait_for(n_rxe, 2);
    rdchk("overrun flag", `UCTE_ADDR_ERRST, 32'h1);
    rdchk("kept data", `UCTE_ADDR_RXBUF, 32'h11);
    i_rem.send(8'h66, 1'b0, 1'b0, 1'b1);
    wait_for(n_rxd, 5);
    rdchk("recovered status", `UCTE_ADDR_ERRST, 32'h0);
    rdchk("recovered data", `UCTE_ADDR_RXBUF, 32'h66);
  endtask
  task automatic t_rx_off();
    apb(1'b1, `UCTE_ADDR_MODE, 32'hc4);
    i_rem.send(8'h55, 1'b0, 1'b0, 1'b1);
    repeat (40) @(posedge pclk);
    chk("disabled done", 32'h5, n_rxd);
    chk("disabled error", 32'h2, n_rxe);
  endtask
  task automatic t_modes();
    apb(1'b1, `UCTE_ADDR_MODE, 32'he6);
    apb(1'b1, `UCTE_ADDR_TXBUF, 32'h12);
    apb(1'b1, `UCTE_ADDR_TXBUF, 32'h34);
    wait_for(n_txd, 4);
    repeat (20) @(posedge pclk);
    chk("third byte", 32'h12, {24'h0, i_rem.rx_q[2]});
    chk("fourth byte", 32'h34, {24'h0, i_rem.rx_q[3]});
    chk("two stop gap", 32'hc, i_rem.gaps[2]);
    apb(1'b1, `UCTE_ADDR_MODE, 32'hfc);
    i_rem.send(8'h33, 1'b1, 1'b1, 1'b1);
    wait_for(n_rxd, 6);
    rdchk("even parity clean", `UCTE_ADDR_ERRST, 32'h0);
    rdchk("even parity data", `UCTE_ADDR_RXBUF, 32'h33);
    i_rem.send(8'h33, 1'b1, 1'b0, 1'b1);
    wait_for(n_rxe, 3);
    rdchk("even parity flag", `UCTE_ADDR_ERRST, 32'h2);
    apb(1'b0, `UCTE_ADDR_RXBUF, 32'h0);
    apb(1'b1, `UCTE_ADDR_MODE, 32'he8);
    i_rem.send(8'hb5, 1'b0, 1'b0, 1'b1);
    wait_for(n_rxd, 7);
    rdchk("zero parity clean", `UCTE_ADDR_ERRST, 32'h0);
    rdchk("seven bit data", `UCTE_ADDR_RXBUF, 32'h35);
    apb(1'b1, `UCTE_ADDR_MODE, 32'he0);
    i_rem.send(8'h45, 1'b0, 1'b0, 1'b1);
    wait_for(n_rxe, 4);
    rdchk("seven bit framing", `UCTE_ADDR_ERRST, 32'h4);
    rdchk("seven bit framing data", `UCTE_ADDR_RXBUF, 32'h45);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    n_txd = 0;
    n_rxd = 0;
    n_rxe = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx_ok();
    t_parity();
    t_framing();
    t_overrun();
    t_rx_off();
    t_modes();
    report_and_stop();
  end
endmodule // tb
